// ===== gpio_board.sv
`timescale 1ns/100ps
module gpio_board (
  input wire logic [1:0] oe,
  input wire logic [1:0] out,
  input wire logic [1:0] ext_en,
  input wire logic [1:0] ext_val,
  output logic [1:0] level
);
  // Pad level: device drive first, then board drive, else pull-up
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      level[i] = oe[i] ? out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : gpio_board

// ===== gpio_group0_consts.svh
`ifndef GPIO_GROUP0_CONSTS_SVH
`define GPIO_GROUP0_CONSTS_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define PIN_DIRECTION_IDX 8'hF0
`define PIN_OUTPUT_VALUE_IDX 8'hF1
`define PIN_LEVEL_STATUS_IDX 8'hF2
`define PIN_DRIVE_TYPE_IDX 8'hF3

// -----------------------------------------------------------------
// Field layout
// -----------------------------------------------------------------
`define FIELD_W 4
`define LINE3_BIT 3
`define LINE2_BIT 2
`define FIELD_MASK_DIR 4'hF
`define STATUS_MASK 4'hC

// -----------------------------------------------------------------
// Reset values of the stored low nibble and of the read data word
// -----------------------------------------------------------------
`define RST_DIRECTION 4'h0
`define RST_OUTPUT_VALUE 4'h3
`define RST_DRIVE_TYPE 4'h0
`define RST_WORD 32'h0000_0000
`define RST_NIBBLE 4'h0

`endif

// ===== gpio_group0_pkg.sv
package gpio_group0_pkg;

  // -----------------------------------------------------------------
  // Common types
  // -----------------------------------------------------------------
  typedef logic [3:0] field_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_DIRECTION,
    SEL_OUTPUT_VALUE,
    SEL_LEVEL_STATUS,
    SEL_DRIVE_TYPE
  } reg_sel_t;

  // State of the core register file
  typedef struct packed {
    field_t direction;
    field_t output_value;
    field_t drive_type;
    word_t rdata;
  } core_state_t;

  // State of the pad input synchroniser
  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } sync_state_t;

  // State of one pad driver
  typedef struct packed {
    logic pad_out;
    logic pad_oe;
  } drive_state_t;

endpackage : gpio_group0_pkg

// ===== gpio_group0_port.sv
`timescale 1ns/100ps
`include "gpio_group0_consts.svh"
module gpio_group0_port (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire gpio_group0_pkg::addr_t PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire gpio_group0_pkg::word_t PWDATA,
  output gpio_group0_pkg::word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic GENERAL_LINE3_IN,
  output logic GENERAL_LINE3_OUT,
  output logic GENERAL_LINE3_OE,
  input wire logic GENERAL_LINE2_IN,
  output logic GENERAL_LINE2_OUT,
  output logic GENERAL_LINE2_OE
);
  import gpio_group0_pkg::*;

  // -----------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------

  // Byte address of a register index
  function automatic addr_t reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction : reg_addr

  // Register selected by a bus address
  function automatic reg_sel_t decode(input addr_t addr);
    if (addr == reg_addr(`PIN_DIRECTION_IDX)) begin
      decode = SEL_DIRECTION;
    end else if (addr == reg_addr(`PIN_OUTPUT_VALUE_IDX)) begin
      decode = SEL_OUTPUT_VALUE;
    end else if (addr == reg_addr(`PIN_LEVEL_STATUS_IDX)) begin
      decode = SEL_LEVEL_STATUS;
    end else if (addr == reg_addr(`PIN_DRIVE_TYPE_IDX)) begin
      decode = SEL_DRIVE_TYPE;
    end else begin
      decode = SEL_NONE;
    end
  endfunction : decode

  // Place a nibble in the low bits of a word, upper bits zero
  function automatic word_t widen(input field_t f);
    widen = {28'h000_0000, f};
  endfunction : widen

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  core_state_t state;
  core_state_t next_state;
  reg_sel_t sel;
  logic setup_phase;
  logic write_strobe;
  logic [1:0] pad_level;
  logic line3_level;
  logic line2_level;
  field_t level_status;
  logic line3_dir;
  logic line2_dir;
  logic line3_out_value;
  logic line2_out_value;
  logic line3_push_pull;
  logic line2_push_pull;

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------

  // Phase and strobe terms; the slave answers with no wait state
  assign sel = decode(PADDR);
  assign setup_phase = PSEL & ~PENABLE;
  assign write_strobe = PSEL & PENABLE & PWRITE & (sel != SEL_NONE);
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & (sel == SEL_NONE); // Unmapped address

  // -----------------------------------------------------------------
  // Pad input sampling
  // -----------------------------------------------------------------

  // Pad levels are asynchronous; two flops before any use
  line_sync u_line_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .async_in({GENERAL_LINE3_IN, GENERAL_LINE2_IN}),
    .sync_out(pad_level)
  );

  // Real pad level, driven or not, feeds the status bits
  assign line3_level = pad_level[1];
  assign line2_level = pad_level[0];

  // Status nibble: reserved bits 1 and 0 read as zero
  always_comb begin
    level_status = `RST_NIBBLE;
    level_status[`LINE3_BIT] = line3_level;
    level_status[`LINE2_BIT] = line2_level;
  end

  // -----------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------

  // Writes on the access phase; read data latched on the setup phase
  always_comb begin
    next_state = state;
    if (write_strobe) begin
      if (sel == SEL_DIRECTION) begin
        next_state.direction = PWDATA[`FIELD_W-1:0];
      end else if (sel == SEL_OUTPUT_VALUE) begin
        next_state.output_value = PWDATA[`FIELD_W-1:0];
      end else if (sel == SEL_DRIVE_TYPE) begin
        next_state.drive_type = PWDATA[`FIELD_W-1:0];
      end
      // Status register takes no write
    end
    if (setup_phase && !PWRITE) begin
      case (sel)
        SEL_DIRECTION: next_state.rdata = widen(state.direction);
        SEL_OUTPUT_VALUE: next_state.rdata = widen(state.output_value);
        SEL_LEVEL_STATUS: next_state.rdata = widen(level_status);
        SEL_DRIVE_TYPE: next_state.rdata = widen(state.drive_type);
        default: next_state.rdata = `RST_WORD;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state.direction <= `RST_DIRECTION;
      state.output_value <= `RST_OUTPUT_VALUE;
      state.drive_type <= `RST_DRIVE_TYPE;
      state.rdata <= `RST_WORD;
    end else begin
      state <= next_state;
    end
  end

  assign PRDATA = state.rdata;

  // -----------------------------------------------------------------
  // Pad drive
  // -----------------------------------------------------------------

  // Per-line control fields
  assign line3_dir = state.direction[`LINE3_BIT];
  assign line2_dir = state.direction[`LINE2_BIT];
  assign line3_out_value = state.output_value[`LINE3_BIT];
  assign line2_out_value = state.output_value[`LINE2_BIT];
  assign line3_push_pull = state.drive_type[`LINE3_BIT];
  assign line2_push_pull = state.drive_type[`LINE2_BIT];

  // Upper line pad
  pad_driver u_drive_line3 (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .dir(line3_dir),
    .out_value(line3_out_value),
    .push_pull(line3_push_pull),
    .pad_out(GENERAL_LINE3_OUT),
    .pad_oe(GENERAL_LINE3_OE)
  );

  // Lower line pad, identical behaviour
  pad_driver u_drive_line2 (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .dir(line2_dir),
    .out_value(line2_out_value),
    .push_pull(line2_push_pull),
    .pad_out(GENERAL_LINE2_OUT),
    .pad_oe(GENERAL_LINE2_OE)
  );

endmodule : gpio_group0_port

// ===== gpio_group0_port_props.sv
`timescale 1ns/100ps
module gpio_group0_port_props (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire gpio_group0_pkg::addr_t PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire gpio_group0_pkg::word_t PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic GENERAL_LINE3_OUT,
  input wire logic GENERAL_LINE3_OE,
  input wire logic GENERAL_LINE2_OUT,
  input wire logic GENERAL_LINE2_OE
);
  import gpio_group0_pkg::*;
  logic [3:0] dir, val, drv;
  // Shadow of the control registers, taken on the write edge
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dir <= 4'h0;
      val <= 4'h3;
      drv <= 4'h0;
    end else if (PSEL && PENABLE && PWRITE) begin
      if (PADDR == 12'h3C0) dir <= PWDATA[3:0];
      if (PADDR == 12'h3C4) val <= PWDATA[3:0];
      if (PADDR == 12'h3CC) drv <= PWDATA[3:0];
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence acc_s;
    PSEL && PENABLE;
  endsequence
  chk_ready_access: assert property (acc_s |-> PREADY)
    else $error("no ready in access phase");
  chk_error_map: assert property (acc_s |-> PSLVERR == (PADDR[11:4] != 8'h3C || PADDR[1:0] != 0))
    else $error("wrong error response");
  chk_l3_input: assert property (!dir[3] |=> !GENERAL_LINE3_OE)
    else $error("line3 driven in input mode");
  chk_l3_push: assert property (dir[3] && drv[3] |=> GENERAL_LINE3_OE && GENERAL_LINE3_OUT == $past(val[3]))
    else $error("line3 push-pull wrong");
  chk_l3_drain: assert property (dir[3] && !drv[3] |=> GENERAL_LINE3_OE != $past(val[3]) && !GENERAL_LINE3_OUT)
    else $error("line3 open drain wrong");
  chk_l2_input: assert property (!dir[2] |=> !GENERAL_LINE2_OE)
    else $error("line2 driven in input mode");
  chk_l2_push: assert property (dir[2] && drv[2] |=> GENERAL_LINE2_OE && GENERAL_LINE2_OUT == $past(val[2]))
    else $error("line2 push-pull wrong");
  chk_l2_drain: assert property (dir[2] && !drv[2] |=> GENERAL_LINE2_OE != $past(val[2]) && !GENERAL_LINE2_OUT)
    else $error("line2 open drain wrong");
endmodule : gpio_group0_port_props
bind gpio_group0_port gpio_group0_port_props props (.SYS_CLK, .RST_N, .PADDR, .PSEL, .PENABLE,
  .PWRITE, .PWDATA, .PREADY, .PSLVERR, .GENERAL_LINE3_OUT, .GENERAL_LINE3_OE,
  .GENERAL_LINE2_OUT, .GENERAL_LINE2_OE);

// ===== line_sync.sv
`timescale 1ns/100ps
module line_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  import gpio_group0_pkg::*;

  sync_state_t state;
  sync_state_t next_state;

  // Two flops; the first stage feeds only the second
  always_comb begin
    next_state = state;
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;

endmodule : line_sync

// ===== pad_driver.sv
`timescale 1ns/100ps
module pad_driver (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dir,
  input wire logic out_value,
  input wire logic push_pull,
  output logic pad_out,
  output logic pad_oe
);
  import gpio_group0_pkg::*;

  drive_state_t state;
  drive_state_t next_state;

  // Pad control from direction, value and drive type
  always_comb begin
    next_state = state;
    if (!dir) begin
      // Input mode: pad released, drive type ignored
      next_state.pad_oe = 1'b0;
      next_state.pad_out = 1'b0;
    end else if (push_pull) begin
      // Push-pull: drive both levels
      next_state.pad_oe = 1'b1;
      next_state.pad_out = out_value;
    end else begin
      // Open drain: pull low only, let the board pull high
      next_state.pad_oe = ~out_value;
      next_state.pad_out = 1'b0;
    end
  end

  // State register; pad released during reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pad_out = state.pad_out;
  assign pad_oe = state.pad_oe;

endmodule : pad_driver

// ===== test_gpio_group0_port.sv
`timescale 1ns/100ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_gpio_group0_port;
  import gpio_group0_pkg::*;
  logic SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
  addr_t PADDR = 0;
  word_t PWDATA = 0, PRDATA;
  logic [1:0] oe, out, lvl, ext_en = 2'b11, ext_val = 2'b00;
  logic [2:0] c3, c2;
  logic [32:0] exp_q[$], exp_r;
  logic [31:0] seed = 32'h23de_dad2;
  int failures = 0, checked = 0;
  // --------------------------------
  // Clock, design and board
  // --------------------------------
  always #2 SYS_CLK = ~SYS_CLK;
  gpio_group0_port dut (.SYS_CLK, .RST_N, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .GENERAL_LINE3_IN(lvl[1]), .GENERAL_LINE3_OUT(out[1]),
    .GENERAL_LINE3_OE(oe[1]), .GENERAL_LINE2_IN(lvl[0]), .GENERAL_LINE2_OUT(out[0]),
    .GENERAL_LINE2_OE(oe[0]));
  gpio_board board (.oe, .out, .ext_en, .ext_val, .level(lvl));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // One APB transfer; the request is kept until the next call or idle
  task automatic apb(logic wr, addr_t a, word_t d, logic [32:0] e);
    PSEL <= 1;
    PENABLE <= 0;
    PADDR <= a;
    PWRITE <= wr;
    PWDATA <= d;
    if (!wr) exp_q.push_back(e);
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
  endtask : apb
  task automatic idle;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge SYS_CLK);
  endtask : idle
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Compare each completed read with the oldest noted result
  always @(posedge SYS_CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      exp_r = exp_q.pop_front();
      `CMP({PSLVERR, PRDATA}, exp_r)
    end
  end
  // Cut a hang short
  initial begin
    #40000;
    failures++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RST_N <= 1;
    @(posedge SYS_CLK);
    apb(0, 12'h3C0, 0, 33'h0);
    apb(0, 12'h3C4, 0, 33'h3);
    apb(0, 12'h3CC, 0, 33'h0);
    apb(0, 12'h3D0, 0, 33'h1_0000_0000);
    apb(0, 12'h3C8, 0, 33'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      apb(1, 12'h3C0 + 12'(i * 4), seed, 0);
      if (i != 2) apb(0, 12'h3C0 + 12'(i * 4), 0, {29'h0, seed[3:0]});
    end
    for (int i = 0; i < 8; i++) begin
      c3 = 3'(i);
      c2 = 3'(7 - i);
      seed = lfsr(seed);
      ext_val <= seed[1:0];
      ext_en <= {~c3[2], ~c2[2]};
      apb(1, 12'h3CC, {28'h0, c3[1], c2[1], 2'b00}, 0);
      apb(1, 12'h3C4, {28'h0, c3[0], c2[0], 2'b00}, 0);
      apb(1, 12'h3C0, {28'h0, c3[2], c2[2], 2'b00}, 0);
      apb(1, 12'h3C8, seed, 0);
      idle();
      repeat (4) @(posedge SYS_CLK);
      `CMP(oe, {c3[2] & (c3[1] | ~c3[0]), c2[2] & (c2[1] | ~c2[0])})
      apb(0, 12'h3C8, 0, {29'h0, c3[2] ? c3[0] : seed[1], c2[2] ? c2[0] : seed[0], 2'b00});
      idle();
    end
    repeat (2) @(posedge SYS_CLK);
    wrap_up();
  end
endmodule : test_gpio_group0_port
